// [hw/interval_counter_map.svh]
// constants for the interval counter channel (modes 3 to 5)
// Operation
// - square wave loads count on next pulse
// - square wave new count waits; trigger loads early
// - square wave untriggered count loads at half-cycle
// - even count: load, minus two, flip, reload
// - odd count: load minus one, asymmetric halves
// - odd count high (N+1)/2, low (N-1)/2
// - square wave output starts high
// - software strobe idles high, one-pulse low strobe
// - software strobe starts on count write
// - gate high counts, low halts, output unaffected
// - software strobe: load pulse, strobe N+1 later
// - software strobe rewrite loads next pulse
// - first byte ignored, second byte loads
// - hardware strobe starts on gate rising edge
// - hardware strobe: load pulse, strobe N+1 later
// - every trigger reloads and restarts
// - hardware strobe rewrite waits for trigger
// - gate sampled on every count clock rise
// - square wave period is N pulses
// - trigger is gate rise; pulse is clock rise
`ifndef INTERVAL_COUNTER_MAP_SVH
`define INTERVAL_COUNTER_MAP_SVH
`define IC_CNT_W        16
`define IC_CNT_ZERO     16'h0000
`define IC_CNT_ONE      16'h0001
`define IC_CNT_TWO      16'h0002
`define IC_MODE_SQUARE  2'h0
`define IC_MODE_SW_STB  2'h1
`define IC_MODE_HW_STB  2'h2
`define IC_LSB_LO       0
`define IC_LSB_HI       7
`define IC_MSB_LO       8
`define IC_MSB_HI       15
`endif

// [hw/interval_counter_pkg.sv]
// types shared by the interval counter channel
`include "interval_counter_map.svh"
package interval_counter_pkg;
  typedef logic [1:0] mode_t;
  typedef struct packed {
    logic       wr_ctrl;
    mode_t      mode;
    logic       two_byte;
    logic       wr_byte;
    logic [7:0] data;
  } cpu_wr_t;
endpackage : interval_counter_pkg

// [hw/ic_edge_detect.sv]
// samples a level on each count-clock rise and flags rising edges
`timescale 1ns/1ps
`default_nettype none
module ic_edge_detect (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  // sampling
  input  wire logic i_sample_en,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_level_r
);
  typedef struct packed {
    logic prev;
    logic rise;
  } ed_state_t;
  ed_state_t st_r;
  ed_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.rise = 1'b0;
    if (i_sample_en) begin
      st_nxt.rise = i_level & ~st_r.prev;
      st_nxt.prev = i_level;
    end
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_rise    = st_r.rise;
  assign o_level_r = st_r.prev;
endmodule : ic_edge_detect
`default_nettype wire

// [hw/ic_count_writer.sv]
// assembles one- or two-byte counts into the count holding register
`timescale 1ns/1ps
`default_nettype none
`include "interval_counter_map.svh"
module ic_count_writer
  import interval_counter_pkg::*;
(
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_sys_rst,
  // cpu writes
  input  wire interval_counter_pkg::cpu_wr_t i_wr,
  // assembled count
  output logic [`IC_CNT_W-1:0]      o_count_holding_register,
  output logic                      o_count_done
);
  typedef struct packed {
    logic [`IC_CNT_W-1:0] chr;
    logic                 two_byte;
    logic                 hi_next;
    logic                 done;
  } cw_state_t;
  cw_state_t st_r;
  cw_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (i_wr.wr_ctrl) begin
      st_nxt.two_byte = i_wr.two_byte;
      st_nxt.hi_next  = 1'b0;
    end else if (i_wr.wr_byte) begin
      if (!st_r.two_byte) begin
        st_nxt.chr  = {8'h00, i_wr.data};
        st_nxt.done = 1'b1;
      end else if (!st_r.hi_next) begin
        st_nxt.chr[`IC_LSB_HI:`IC_LSB_LO] = i_wr.data;
        st_nxt.hi_next = 1'b1;
      end else begin
        st_nxt.chr[`IC_MSB_HI:`IC_MSB_LO] = i_wr.data;
        st_nxt.hi_next = 1'b0;
        st_nxt.done    = 1'b1;
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_count_holding_register = st_r.chr;
  assign o_count_done             = st_r.done;
endmodule : ic_count_writer
`default_nettype wire

// [hw/interval_counter.sv]
// one interval counter channel: square wave, software and hardware strobes
`timescale 1ns/1ps
`default_nettype none
`include "interval_counter_map.svh"
module interval_counter
  import interval_counter_pkg::*;
(
  // clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_sys_rst,
  // cpu write port
  input  wire interval_counter_pkg::cpu_wr_t i_wr,
  // counter pins
  input  wire logic                          i_cnt_clk_en,
  input  wire logic                          i_gate,
  output logic                               o_out,
  // status
  output logic [`IC_CNT_W-1:0]               o_count,
  output logic                               o_null_count
);
  import interval_counter_pkg::*;

  typedef struct packed {
    mode_t                mode;
    logic                 programmed;
    logic                 running;
    logic                 load_pend;
    logic                 new_pend;
    logic                 trig_pend;
    logic                 out;
    logic                 odd_low_pend;
    logic [`IC_CNT_W-1:0] ce;
    logic [`IC_CNT_W-1:0] init;
    // count that governs the running square wave; init may already hold a newer one
    logic [`IC_CNT_W-1:0] cur;
  } ch_state_t;

  ch_state_t            st_r;
  ch_state_t            st_nxt;
  logic [`IC_CNT_W-1:0] chr;
  logic                 count_done;
  logic                 trig;
  logic                 pulse;

  // load value for square wave: odd counts drop to even
  function automatic logic [`IC_CNT_W-1:0] sq_load(input logic [`IC_CNT_W-1:0] n);
    sq_load = {n[`IC_CNT_W-1:1], 1'b0};
  endfunction : sq_load

  ic_count_writer u_writer (
    .i_core_clk               (i_core_clk),
    .i_sys_rst                (i_sys_rst),
    .i_wr                     (i_wr),
    .o_count_holding_register (chr),
    .o_count_done             (count_done)
  );

  ic_edge_detect u_gate (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_sample_en (i_cnt_clk_en),
    .i_level     (i_gate),
    .o_rise      (trig),
    .o_level_r   ()
  );

  // the edge detector reports a trigger one cycle after its sample, so
  // the pending flag carries it to the next count-clock pulse
  assign pulse = i_cnt_clk_en;

  // a pulse is never lost to a count write in the same cycle, and a trigger
  // that meets its own consumption is kept: the set comes last and wins
  always_comb begin
    st_nxt = st_r;
    if (i_wr.wr_ctrl) begin
      st_nxt            = '0;
      st_nxt.mode       = i_wr.mode;
      st_nxt.programmed = 1'b1;
      st_nxt.out        = 1'b1;
      st_nxt.ce         = st_r.ce;
    end else begin
      if (pulse && st_r.programmed) begin
        case (st_r.mode)
          `IC_MODE_SQUARE: begin
            if (st_r.load_pend || (st_r.trig_pend && st_r.new_pend)) begin
              st_nxt.ce           = sq_load(st_r.init);
              st_nxt.cur          = st_r.init;
              st_nxt.running      = 1'b1;
              st_nxt.load_pend    = 1'b0;
              st_nxt.new_pend     = 1'b0;
              st_nxt.trig_pend    = 1'b0;
              st_nxt.odd_low_pend = 1'b0;
            end else if (st_r.running && i_gate) begin
              st_nxt.trig_pend = 1'b0;
              if (st_r.odd_low_pend) begin
                // odd count: the high half ends one pulse after expiry, then a full reload
                st_nxt.out          = 1'b0;
                st_nxt.odd_low_pend = 1'b0;
                st_nxt.cur          = st_r.init;
                st_nxt.ce           = sq_load(st_r.init);
                st_nxt.new_pend     = 1'b0;
              end else if (st_r.ce <= `IC_CNT_TWO) begin
                if (st_r.cur[0] && st_r.out) begin
                  st_nxt.odd_low_pend = 1'b1;
                  st_nxt.ce           = `IC_CNT_ZERO;
                end else begin
                  // half-cycle done: a count written meanwhile takes effect here
                  st_nxt.out      = ~st_r.out;
                  st_nxt.cur      = st_r.init;
                  st_nxt.ce       = sq_load(st_r.init);
                  st_nxt.new_pend = 1'b0;
                end
              end else begin
                st_nxt.ce = st_r.ce - `IC_CNT_TWO;
              end
            end
          end
          `IC_MODE_SW_STB: begin
            st_nxt.out = 1'b1;
            if (st_r.load_pend) begin
              st_nxt.ce        = st_r.init;
              st_nxt.running   = 1'b1;
              st_nxt.load_pend = 1'b0;
              st_nxt.new_pend  = 1'b0;
            end else if (st_r.running && i_gate) begin
              if (st_r.ce == `IC_CNT_ONE) begin
                st_nxt.out     = 1'b0;
                st_nxt.running = 1'b0;
              end
              st_nxt.ce = st_r.ce - `IC_CNT_ONE;
            end
          end
          `IC_MODE_HW_STB: begin
            st_nxt.out = 1'b1;
            if (st_r.trig_pend) begin
              st_nxt.ce        = st_r.init;
              st_nxt.running   = 1'b1;
              st_nxt.trig_pend = 1'b0;
              st_nxt.new_pend  = 1'b0;
            end else if (st_r.running) begin
              if (st_r.ce == `IC_CNT_ONE) begin
                st_nxt.out     = 1'b0;
                st_nxt.running = 1'b0;
              end
              st_nxt.ce = st_r.ce - `IC_CNT_ONE;
            end
          end
          default: begin
            st_nxt.out = 1'b1;
          end
        endcase
      end
      if (count_done) begin
        st_nxt.init     = chr;
        st_nxt.new_pend = 1'b1;
        case (st_r.mode)
          `IC_MODE_SQUARE: begin
            if (!st_r.running) begin
              st_nxt.load_pend = 1'b1;
            end else begin
              st_nxt.trig_pend = 1'b0;
            end
          end
          `IC_MODE_SW_STB: begin
            st_nxt.load_pend = 1'b1;
          end
          default: begin
          end
        endcase
      end
      if (trig && st_r.mode != `IC_MODE_SW_STB) begin
        st_nxt.trig_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r     <= '0;
      st_r.out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_out        = st_r.out;
  assign o_count      = st_r.ce;
  assign o_null_count = st_r.new_pend;
endmodule : interval_counter
`default_nettype wire

// [testbench/interval_counter_monitor.sv]
// port assertions for the interval counter channel
`timescale 1ns/1ps
`default_nettype none
`include "interval_counter_map.svh"
module interval_counter_monitor
  import interval_counter_pkg::*;
(
  // clock and reset
  input wire logic                          i_core_clk,
  input wire logic                          i_sys_rst,
  // watched ports
  input wire interval_counter_pkg::cpu_wr_t i_wr,
  input wire logic                          i_cnt_clk_en,
  input wire logic                          i_gate,
  input wire logic                          o_out,
  input wire logic [`IC_CNT_W-1:0]          o_count,
  input wire logic                          o_null_count
);
  mode_t mode_r;
  logic  gate_r;
  logic  null_r;
  logic  ctrl_r;
  logic  loaded_r;
  // gate as seen on the last pulse, so a square-wave trigger is excluded;
  // loaded_r: a count reached the counter since the last mode write, since a
  // mode write keeps a stale count that must not be stepped
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_r   <= `IC_MODE_SQUARE;
      gate_r   <= 1'b0;
      null_r   <= 1'b0;
      ctrl_r   <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      null_r <= o_null_count;
      ctrl_r <= i_wr.wr_ctrl;
      if (i_wr.wr_ctrl) mode_r <= i_wr.mode;
      if (i_cnt_clk_en) gate_r <= i_gate;
      if (i_wr.wr_ctrl) begin
        loaded_r <= 1'b0;
      end else if (null_r && !o_null_count && !ctrl_r) begin
        loaded_r <= 1'b1;
      end
    end
  end
  wire logic pul = i_cnt_clk_en && !i_wr.wr_ctrl;
  wire logic cnt = pul && i_gate && !o_null_count;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_out_cause: assert property (!$stable(o_out) |-> $past(i_cnt_clk_en) || $past(i_wr.wr_ctrl))
    else $error("out moved off a pulse");
  a_count_cause: assert property (!$stable(o_count) |-> $past(i_cnt_clk_en) || $past(i_wr.wr_ctrl))
    else $error("count moved off a pulse");
  a_load_point: assert property ($fell(o_null_count) |-> $past(i_cnt_clk_en) || $past(i_wr.wr_ctrl))
    else $error("load off a pulse");
  a_mode_high: assert property (i_wr.wr_ctrl && !i_cnt_clk_en |=> o_out)
    else $error("out low after mode write");
  a_strobe_one: assert property (mode_r != `IC_MODE_SQUARE && !o_out && pul |=> o_out)
    else $error("strobe longer than one pulse");
  a_gate_halt: assert property (mode_r == `IC_MODE_SW_STB && pul && !i_gate && !o_null_count |=> $stable(o_count))
    else $error("count moved with gate low");
  a_sw_step: assert property (mode_r == `IC_MODE_SW_STB && cnt && loaded_r && o_count != `IC_CNT_ZERO |=>
      o_count == $past(o_count) - `IC_CNT_ONE) else $error("strobe count step wrong");
  a_square_step: assert property (mode_r == `IC_MODE_SQUARE && cnt && gate_r && loaded_r && o_count > `IC_CNT_TWO |=>
      o_count == $past(o_count) - `IC_CNT_TWO) else $error("square count step wrong");
endmodule : interval_counter_monitor
bind interval_counter interval_counter_monitor u_monitor (
  .i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst),
  .i_wr(i_wr),
  .i_cnt_clk_en(i_cnt_clk_en),
  .i_gate(i_gate),
  .o_out(o_out),
  .o_count(o_count),
  .o_null_count(o_null_count)
);
`default_nettype wire

// [testbench/ic_cpu_model.sv]
// cpu side: mode words and count bytes, one cycle each
`timescale 1ns/1ps
`default_nettype none
module ic_cpu_model
  import interval_counter_pkg::*;
(
  // clock
  input  wire logic                         i_core_clk,
  // write port
  output var interval_counter_pkg::cpu_wr_t o_wr
);
  initial o_wr = '0;
  // released byte is inverted so a stale value is never taken for fresh
  task automatic put(input logic c, input mode_t m, input logic t, input logic [7:0] d);
    @(posedge i_core_clk);
    o_wr <= cpu_wr_t'{c, m, t, !c, d};
    @(posedge i_core_clk);
    o_wr <= cpu_wr_t'{1'b0, m, t, 1'b0, ~d};
  endtask : put
  task automatic ctrl(input mode_t m, input logic t);
    put(1'b1, m, t, 8'h00);
  endtask : ctrl
  task automatic wbyte(input logic [7:0] d);
    put(1'b0, o_wr.mode, o_wr.two_byte, d);
  endtask : wbyte
endmodule : ic_cpu_model
`default_nettype wire

// [testbench/interval_counter_modes_3_to_5_test.sv]
// bench with a reference model of the channel
`timescale 1ns/1ps
`default_nettype none
module interval_counter_modes_3_to_5_test;
  import interval_counter_pkg::*;
  logic        clk;
  logic        rst;
  logic        en;
  logic        gate;
  logic        o_out;
  logic        o_null;
  logic [15:0] o_cnt;
  cpu_wr_t     wr;
  int error_cnt, compares, cyc, seed, md, nv, cr, k, ou, run, trg, gp, n, i;
  int pq[$];
  interval_counter DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_wr(wr), .i_cnt_clk_en(en), .i_gate(gate),
    .o_out(o_out), .o_count(o_cnt), .o_null_count(o_null));
  ic_cpu_model cpu (.i_core_clk(clk), .o_wr(wr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", s, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic load();
    nv = cr;
    run = 1;
    k = 0;
    pq.delete();
  endtask : load
  task automatic step(input logic g);
    if (md != 0 && ou == 0) ou = 1;
    if (md == 1 && pq.size() != 0) load();
    else if (md == 2 && trg != 0) load();
    else if (md == 0 && pq.size() != 0 && run == 0) load();
    else if (md != 0 && run != 0 && (g || md == 2)) begin
      nv--;
      if (nv == 0) begin
        ou = 0;
        run = 0;
      end
    end else if (md == 0 && run != 0 && g) begin
      k++;
      if (k == (ou != 0 ? (nv + 1) / 2 : nv / 2)) begin
        ou = !ou;
        k = 0;
        if (pq.size() != 0) load();
      end
    end
    trg = g && !gp;
    gp = g;
  endtask : step
  task automatic pulse(input logic g);
    @(posedge clk);
    if (md != 0 && run != 0 && nv == 1) g = gate;
    gate <= g;
    repeat (2) @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    en <= 1'b0;
    step(g);
    @(posedge clk);
    #1;
    chk("out", o_out, ou);
    chk("null", o_null, pq.size() != 0);
    if (md != 0 && run != 0) chk("count", o_cnt, nv);
  endtask : pulse
  task automatic wcnt(input int v, input logic two);
    if (two) begin
      cpu.wbyte(v[7:0]);
      pulse(gate);
    end
    cpu.wbyte(two ? v[15:8] : v[7:0]);
    cr = v;
    pq.push_back(v);
  endtask : wcnt
  task automatic mode_set(input int m, input logic two);
    cpu.ctrl(m[1:0], two);
    md = m;
    ou = 1;
    run = 0;
    trg = 0;
    pq.delete();
  endtask : mode_set
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    seed = 26414;
    rst = 1'b1;
    en = 1'b0;
    gate = 1'b0;
    ou = 1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("out", o_out, 1);
    chk("count", o_cnt, 0);
    // software strobe: strobe on pulse N+1, then random gate with two-byte rewrites
    mode_set(1, 0);
    wcnt(3, 0);
    repeat (6) pulse(1'b1);
    mode_set(1, 1);
    for (i = 0; i < 30; i++) begin
      if (i % 10 == 4) wcnt(2 + $unsigned($random(seed)) % 6, 1);
      pulse(1'($random(seed)));
    end
    // hardware strobe: waits for a rise, retriggers, new count waits for trigger
    pulse(1'b0);
    mode_set(2, 0);
    wcnt(4, 0);
    for (i = 0; i < 40; i++) begin
      if (i == 12) wcnt(3, 0);
      pulse(i % 9 == 1 || i == 21);
    end
    repeat (2) pulse(1'b1);
    // square wave: even and odd counts, rewrite waits for the half-cycle
    for (i = 0; i < 4; i++) begin
      n = 2 + i + 2 * ($unsigned($random(seed)) % 3);
      mode_set(0, 0);
      wcnt(n, 0);
      repeat (2 * n + 1) pulse(1'b1);
      wcnt(n + 1, 0);
      repeat (3 * n) pulse(1'b1);
    end
    give_verdict();
  end
endmodule : interval_counter_modes_3_to_5_test
`default_nettype wire
